//--- hw/oor_pkg.sv
/*
 * Constants and types shared by the output override register block.
 * Assumes a 250 MHz core clock and register numbers used as addresses.
 */
package oor_pkg;
	// ************************************************************
	// Register numbers
	// ************************************************************
	localparam logic [15:0] ADR_DELAY_B = 16'h9C53;
	localparam logic [15:0] ADR_AO_B    = 16'h9C54;
	localparam logic [15:0] ADR_CSR     = 16'h9C55;
	localparam logic [15:0] ADR_DELAY_E = 16'h9C63;
	localparam logic [15:0] ADR_MODE    = 16'h9C64;
	localparam logic [15:0] ADR_AO_E    = 16'h9C65;
	localparam logic [15:0] ADR_SPST    = 16'h9C66;

	// ************************************************************
	// Field positions and values
	// ************************************************************
	localparam logic [15:0] UNUSED_VAL  = 16'h8000;
	localparam logic [15:0] AO_MAX_W    = 16'h0FFF;
	localparam logic [11:0] AO_MAX      = 12'hFFF;
	localparam int          CSR_MAN_BIT = 4;
	localparam logic [4:0]  MODE_RST    = 5'h00;
	localparam logic [3:0]  SP_RST      = 4'h0;
	localparam logic [11:0] AO_RST      = 12'h000;
	localparam logic [15:0] DELAY_RST   = 16'h0002;
	localparam logic [15:0] EL_MAX      = 16'hFFFF;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          CHAR_TIMES    = 2;
	localparam int          FLOOR_MS      = 2;
	localparam int          BAUD_BASE     = 300;
	localparam int          MS_PER_S      = 1000;
	localparam int          FRAME_MIN     = 9;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          MS_NS         = 1000000;
	localparam int          MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam logic [1:0]  SYNC_WAIT     = 2'h2;

	typedef enum logic [2:0] {
		ST_SYNC = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN  = 3'b100
	} oor_state_t;
endpackage

//--- hw/oor_top.sv
/*
 * Output override register bank: auto/manual select, setpoint state,
 * analog level and response delay with power-up reconciliation.
 * Assumes a frame parser on the same clock issues register reads and
 * writes, flags each received character and a pending reply; the
 * meter logic and the nonvolatile store also share the clock.
 */
// Function
// RQ1 - One select bit per output, 1 manual
// RQ2 - Manual setpoints follow setpoint state word
// RQ3 - Entering manual holds last output value
// RQ4 - Select bit layout depends on variant
// RQ5 - Setpoint state read returns present outputs
// RQ6 - State write acts only in manual
// RQ7 - State bit 0 is setpoint one
// RQ8 - Analog level is 12-bit unsigned code
// RQ9 - Analog writes above 4095 saturate
// RQ10 - Master enables analog manual before use
// RQ11 - Manual analog write updates output immediately
// RQ12 - Auto analog write stored, applied later
// RQ13 - Unused registers read 8000h
// RQ14 - Reply waits response delay after query
// RQ15 - Delay writes below minimum are discarded
// RQ16 - Power-up delay is max of stored, computed
// RQ17 - Master writes select pattern for manual
// RQ18 - Basic manual drives setpoints from control word
// RQ19 - Basic auto write only clears setpoints
// RQ20 - All outputs start in automatic mode
// RQ21 - Minimum delay from straps, timer gates reply
module oor_top
	import oor_pkg::*;
#(
	parameter bit EXT_MAP    = 1'b1,
	parameter bit HAS_ANALOG = 1'b1,
	parameter int MS_CYCLES  = MS_CYCLES_DEF
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [15:0] REG_ADDR_I,
	input  wire logic [15:0] REG_WDATA_I,
	output logic      [15:0] REG_RDATA_O,
	output logic             REG_RVALID_O,
	input  wire logic [3:0]  METER_SP_I,
	input  wire logic [11:0] METER_AO_I,
	output logic      [3:0]  SP_OUT_O,
	output logic      [3:0]  SP_CLEAR_O,
	output logic      [11:0] AO_OUT_O,
	output logic             AO_MANUAL_O,
	input  wire logic [2:0]  STRAP_BAUD_I,
	input  wire logic        STRAP_DATA8_I,
	input  wire logic        STRAP_PARITY_I,
	input  wire logic        NVM_VALID_I,
	input  wire logic [15:0] NVM_DELAY_I,
	output logic             NVM_WR_O,
	output logic      [15:0] NVM_WDATA_O,
	input  wire logic        RX_CHAR_I,
	input  wire logic        REPLY_PENDING_I,
	output logic             TX_START_O,
	output logic             READY_O
);
	localparam int PW = $clog2(MS_CYCLES + 1);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Two character times in ms, rounded up, never under the floor
	function automatic logic [15:0] min_delay(input logic [2:0] sel,
		input logic b8, input logic par);
		int bits;
		int num;
		int den;
		int q;
		bits = FRAME_MIN + int'(b8) + int'(par);
		num = CHAR_TIMES * MS_PER_S * bits;
		den = BAUD_BASE << sel;
		q = (num + den - 1) / den;
		if (q < FLOOR_MS) begin
			q = FLOOR_MS;
		end
		return 16'(q);
	endfunction

	// Manual flags {analog, sp4..sp1} from the stored select bits
	function automatic logic [4:0] man_of(input logic [4:0] m);
		logic [4:0] r;
		r = 5'h00;
		if (!EXT_MAP) begin
			r = {5{m[CSR_MAN_BIT]}}; // RQ18
		end else begin
			for (int k = 0; k < 4; k++) begin
				r[k] = HAS_ANALOG ? m[4 - k] : m[3 - k]; // RQ4
			end
			r[4] = HAS_ANALOG & m[0]; // RQ4
		end
		return r;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	oor_state_t  st_reg, st_next;
	logic [1:0]  cnt_reg, cnt_next;
	logic [15:0] min_reg, min_next;
	logic [15:0] delay_reg, delay_next;
	logic        nvw_reg, nvw_next;
	logic [15:0] nvd_reg, nvd_next;
	logic [4:0]  sync1_reg, sync2_reg;
	logic [4:0]  mode_reg, mode_next;
	logic [3:0]  sp_man_reg, sp_man_next;
	logic [3:0]  sp_out_reg, sp_out_next;
	logic [3:0]  clr_reg, clr_next;
	logic [11:0] ao_reg, ao_next;
	logic [11:0] ao_out_reg, ao_out_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        rvalid_reg, rvalid_next;
	logic [PW-1:0] pre_reg, pre_next;
	logic [15:0] el_reg, el_next;
	logic        tx_reg, tx_next;
	logic [4:0]  man_cur, man_nx;
	logic        run, wr_mode, wr_sp, wr_ao, wr_dly;

	// Writes are only taken once the delay is reconciled
	assign run     = (st_reg == ST_RUN);
	assign wr_mode = run & REG_WR_I
		& (REG_ADDR_I == (EXT_MAP ? ADR_MODE : ADR_CSR));
	assign wr_sp   = run & REG_WR_I
		& (REG_ADDR_I == (EXT_MAP ? ADR_SPST : ADR_CSR));
	assign wr_ao   = run & REG_WR_I & HAS_ANALOG
		& (REG_ADDR_I == (EXT_MAP ? ADR_AO_E : ADR_AO_B));
	assign wr_dly  = run & REG_WR_I
		& (REG_ADDR_I == (EXT_MAP ? ADR_DELAY_E : ADR_DELAY_B));

	// ************************************************************
	// Strap synchroniser
	// ************************************************************
	// Straps are pins; only the second stage is read
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {STRAP_BAUD_I, STRAP_DATA8_I, STRAP_PARITY_I};
			sync2_reg <= sync1_reg;
		end
	end

	// ************************************************************
	// Power-up reconciliation and response delay
	// ************************************************************
	// Straps are captured once, so later changes need a power cycle
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		min_next = min_reg;
		delay_next = delay_reg;
		nvw_next = 1'b0;
		nvd_next = nvd_reg;
		unique case (st_reg)
			ST_SYNC: begin
				cnt_next = cnt_reg + 2'h1;
				if (cnt_reg == SYNC_WAIT) begin
					min_next = min_delay(sync2_reg[4:2], sync2_reg[1],
						sync2_reg[0]); // RQ21
					st_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (NVM_VALID_I) begin
					delay_next = (NVM_DELAY_I > min_reg) ?
						NVM_DELAY_I : min_reg; // RQ16
					st_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (wr_dly && (REG_WDATA_I >= min_reg)) begin // RQ15
					delay_next = REG_WDATA_I;
					nvw_next = 1'b1;
					nvd_next = REG_WDATA_I;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_reg <= ST_SYNC;
			cnt_reg <= 2'h0;
			min_reg <= DELAY_RST;
			delay_reg <= DELAY_RST;
			nvw_reg <= 1'b0;
			nvd_reg <= DELAY_RST;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			min_reg <= min_next;
			delay_reg <= delay_next;
			nvw_reg <= nvw_next;
			nvd_reg <= nvd_next;
		end
	end

	// ************************************************************
	// Turnaround timer
	// ************************************************************
	// Every received character restarts the wait; elapsed saturates
	always_comb begin
		pre_next = pre_reg + PW'(1);
		el_next = el_reg;
		if (RX_CHAR_I) begin
			pre_next = '0;
			el_next = 16'h0000;
		end else if (pre_reg == PW'(MS_CYCLES - 1)) begin
			pre_next = '0;
			if (el_reg != EL_MAX) begin
				el_next = el_reg + 16'h0001;
			end
		end
		tx_next = run & REPLY_PENDING_I & ~RX_CHAR_I
			& (el_reg >= delay_reg); // RQ14
	end

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pre_reg <= '0;
			el_reg <= 16'h0000;
			tx_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			el_reg <= el_next;
			tx_reg <= tx_next;
		end
	end

	// ************************************************************
	// Override registers and outputs
	// ************************************************************
	assign man_cur = man_of(mode_reg); // RQ1
	assign man_nx  = man_of(mode_next);

	// Hold value is what the output takes this edge, so no glitch
	always_comb begin
		mode_next = mode_reg;
		sp_man_next = sp_man_reg;
		ao_next = ao_reg;
		clr_next = 4'h0;
		if (wr_mode) begin
			if (!EXT_MAP) begin
				mode_next = {REG_WDATA_I[CSR_MAN_BIT], 4'h0};
			end else if (HAS_ANALOG) begin
				mode_next = REG_WDATA_I[4:0];
			end else begin
				mode_next = {1'b0, REG_WDATA_I[3:0]};
			end
		end
		sp_out_next = (man_cur[3:0] & sp_man_reg)
			| (~man_cur[3:0] & METER_SP_I); // RQ2
		ao_out_next = man_cur[4] ? ao_reg : METER_AO_I; // RQ12
		for (int k = 0; k < 4; k++) begin
			if (man_nx[k] && !man_cur[k]) begin
				sp_man_next[k] = sp_out_next[k]; // RQ3
			end
			if (wr_sp && man_nx[k]) begin
				sp_man_next[k] = REG_WDATA_I[k]; // RQ6 RQ7
			end
		end
		// Basic map in auto may only knock setpoints off
		if (!EXT_MAP && wr_sp && !REG_WDATA_I[CSR_MAN_BIT]) begin
			clr_next = ~REG_WDATA_I[3:0]; // RQ19
		end
		if (wr_ao) begin
			ao_next = (REG_WDATA_I > AO_MAX_W) ?
				AO_MAX : REG_WDATA_I[11:0]; // RQ8 RQ9 RQ11
		end
		rvalid_next = REG_RD_I;
		rdata_next = UNUSED_VAL; // RQ13
		if (REG_ADDR_I == (EXT_MAP ? ADR_DELAY_E : ADR_DELAY_B)) begin
			rdata_next = delay_reg;
		end else if (HAS_ANALOG
			&& REG_ADDR_I == (EXT_MAP ? ADR_AO_E : ADR_AO_B)) begin
			rdata_next = {4'h0, ao_reg};
		end else if (EXT_MAP && REG_ADDR_I == ADR_MODE) begin
			rdata_next = {11'h000, mode_reg};
		end else if (EXT_MAP && REG_ADDR_I == ADR_SPST) begin
			rdata_next = {12'h000, sp_out_reg}; // RQ5
		end else if (!EXT_MAP && REG_ADDR_I == ADR_CSR) begin
			rdata_next = {11'h000, mode_reg[CSR_MAN_BIT], sp_out_reg};
		end
		// Read data holds between reads so a slow master still sees it
		if (!REG_RD_I) begin
			rdata_next = rdata_reg;
		end
	end

	// Select bits clear at reset so every output starts automatic
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_reg <= MODE_RST; // RQ20
			sp_man_reg <= SP_RST;
			sp_out_reg <= SP_RST;
			clr_reg <= SP_RST;
			ao_reg <= AO_RST;
			ao_out_reg <= AO_RST;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			sp_man_reg <= sp_man_next;
			sp_out_reg <= sp_out_next;
			clr_reg <= clr_next;
			ao_reg <= ao_next;
			ao_out_reg <= ao_out_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign REG_RDATA_O  = rdata_reg;
	assign REG_RVALID_O = rvalid_reg;
	assign SP_OUT_O     = sp_out_reg;
	assign SP_CLEAR_O   = clr_reg;
	assign AO_OUT_O     = ao_out_reg;
	assign AO_MANUAL_O  = man_cur[4];
	assign NVM_WR_O     = nvw_reg;
	assign NVM_WDATA_O  = nvd_reg;
	assign TX_START_O   = tx_reg;
	assign READY_O      = run;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);

	sequence s_sp1_enter;
		EXT_MAP && !man_cur[0] ##1 man_cur[0] && !wr_sp;
	endsequence
	sequence s_sp2_write;
		wr_sp && man_cur[1] ##1 man_cur[1];
	endsequence

	property p_auto_follow;
		!man_cur[0] |=> SP_OUT_O[0] == $past(METER_SP_I[0]);
	endproperty
	a_auto_follow: assert property (p_auto_follow) // RQ1
		else $error("auto setpoint does not follow meter");

	property p_man_drive;
		s_sp2_write |=> SP_OUT_O[1] == $past(REG_WDATA_I[1], 2);
	endproperty
	a_man_drive: assert property (p_man_drive) // RQ2
		else $error("manual setpoint ignores written bit");

	property p_hold;
		s_sp1_enter |=> SP_OUT_O[0] == $past(SP_OUT_O[0]);
	endproperty
	a_hold: assert property (p_hold) // RQ3
		else $error("setpoint moved on entering manual");

	property p_auto_ignore;
		EXT_MAP && wr_sp && !man_cur[2]
			|=> sp_man_reg[2] == $past(sp_man_reg[2]);
	endproperty
	a_auto_ignore: assert property (p_auto_ignore) // RQ6
		else $error("auto setpoint took a state write");

	property p_sp_read;
		REG_RD_I && EXT_MAP && REG_ADDR_I == ADR_SPST
			|=> REG_RDATA_O == {12'h000, $past(SP_OUT_O)};
	endproperty
	a_sp_read: assert property (p_sp_read) // RQ5
		else $error("state read differs from outputs");

	property p_clamp;
		wr_ao && REG_WDATA_I > AO_MAX_W |=> ao_reg == AO_MAX;
	endproperty
	a_clamp: assert property (p_clamp) // RQ9
		else $error("analog level not saturated");

	property p_ao_man;
		wr_ao && man_cur[4] && REG_WDATA_I <= AO_MAX_W ##1 man_cur[4]
			|=> AO_OUT_O == $past(REG_WDATA_I[11:0], 2);
	endproperty
	a_ao_man: assert property (p_ao_man) // RQ11
		else $error("manual analog did not update");

	property p_ao_auto;
		!man_cur[4] |=> AO_OUT_O == $past(METER_AO_I);
	endproperty
	a_ao_auto: assert property (p_ao_auto) // RQ12
		else $error("auto analog not from meter");

	property p_unused;
		REG_RD_I && REG_ADDR_I == ADR_DELAY_E - 16'h0001
			|=> REG_RDATA_O == UNUSED_VAL;
	endproperty
	a_unused: assert property (p_unused) // RQ13
		else $error("unused register not 8000h");

	property p_tx_wait;
		$rose(TX_START_O) |-> $past(el_reg) >= $past(delay_reg);
	endproperty
	a_tx_wait: assert property (p_tx_wait) // RQ14
		else $error("reply started before delay");

	property p_tx_restart;
		run && RX_CHAR_I |=> !TX_START_O [*8];
	endproperty
	a_tx_restart: assert property (p_tx_restart) // RQ21
		else $error("reply too soon after character");

	property p_floor;
		run |-> delay_reg >= min_reg && delay_reg >= DELAY_RST;
	endproperty
	a_floor: assert property (p_floor) // RQ15
		else $error("delay below computed minimum");

	property p_load;
		st_reg == ST_LOAD && NVM_VALID_I |=> delay_reg
			== (($past(NVM_DELAY_I) > min_reg) ?
			$past(NVM_DELAY_I) : min_reg);
	endproperty
	a_load: assert property (p_load) // RQ16
		else $error("power-up delay not the larger");

	property p_start_auto;
		!run |-> mode_reg == MODE_RST;
	endproperty
	a_start_auto: assert property (p_start_auto) // RQ20
		else $error("outputs not automatic at start");
endmodule

//--- test/oor_master_model.sv
/*
 * Register master model: issues single reads and writes to the
 * override register bank, one word each, on the core clock.
 * Assumes the bank answers a read exactly one cycle after it is taken.
 */
module oor_master_model (
	input  wire logic        clk_i,
	input  wire logic        rvalid_i,
	input  wire logic [15:0] rdata_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [15:0] addr_o,
	output logic      [15:0] wdata_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// Idle bus
	// ************************************************************
	// Address and data start with a value that is never a register
	initial begin
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		addr_o  = 16'h0000;
		wdata_o = 16'hFFFF;
	end

	// ************************************************************
	// Transfers
	// ************************************************************
	// One write pulse; lines are inverted after so stale data never
	// looks valid. Callers may write the analog level in auto as well as in manual.
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		#1;
		wr_o    = 1'b1;
		addr_o  = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
		wr_o    = 1'b0;
		addr_o  = ~a;
		wdata_o = ~d;
	endtask

	// One read pulse; a missing answer returns unknown to the caller
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_i);
		#1;
		rd_o   = 1'b1;
		addr_o = a;
		@(posedge clk_i);
		#1;
		rd_o   = 1'b0;
		addr_o = ~a;
		@(posedge clk_i);
		d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
		#1;
	endtask
endmodule

//--- test/oor_top_tb.sv
/*
 * Self-checking bench for the output override register bank.
 * Drives the extended map and a basic-map copy, both with analog output and a shortened
 * millisecond count; straps give a computed minimum delay of 2 ms.
 */
module oor_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import oor_pkg::*;

	localparam int MSC = 10;

	logic        clk, rst_n, wr, rd, rvalid, ao_man, nvm_wr;
	logic        rx_char, pending, tx_start, ready;
	logic [15:0] addr, wdata, rdata, nvm_wdata, v;
	logic [3:0]  meter_sp, sp_out, sp_clr;
	logic [11:0] meter_ao, ao_out;
	logic [15:0] nvm_delay, rdata_b;
	logic [3:0]  sp_out_b, sp_clr_b;
	logic [2:0]  baud;
	logic        nvm_valid, d8, par;
	int          fails, comparisons, n;

	// ************************************************************
	// Clock, master and design
	// ************************************************************
	always #2 clk = ~clk;

	oor_master_model master (.clk_i(clk), .rvalid_i(rvalid),
		.rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata));

	// Stored delay 5 ms exceeds the 2 ms computed at 38400 baud
	oor_top #(.EXT_MAP(1'b1), .HAS_ANALOG(1'b1), .MS_CYCLES(MSC)) dut (
		.CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.METER_SP_I(meter_sp), .METER_AO_I(meter_ao),
		.SP_OUT_O(sp_out), .SP_CLEAR_O(sp_clr), .AO_OUT_O(ao_out),
		.AO_MANUAL_O(ao_man), .STRAP_BAUD_I(baud),
		.STRAP_DATA8_I(d8), .STRAP_PARITY_I(par),
		.NVM_VALID_I(nvm_valid), .NVM_DELAY_I(nvm_delay),
		.NVM_WR_O(nvm_wr), .NVM_WDATA_O(nvm_wdata),
		.RX_CHAR_I(rx_char), .REPLY_PENDING_I(pending),
		.TX_START_O(tx_start), .READY_O(ready));

	// Basic map copy shares the bus; its register numbers differ
	oor_top #(.EXT_MAP(1'b0), .HAS_ANALOG(1'b1), .MS_CYCLES(MSC))
		dut_basic (
		.CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata_b), .REG_RVALID_O(),
		.METER_SP_I(meter_sp), .METER_AO_I(meter_ao),
		.SP_OUT_O(sp_out_b), .SP_CLEAR_O(sp_clr_b), .AO_OUT_O(),
		.AO_MANUAL_O(), .STRAP_BAUD_I(baud),
		.STRAP_DATA8_I(d8), .STRAP_PARITY_I(par),
		.NVM_VALID_I(nvm_valid), .NVM_DELAY_I(nvm_delay),
		.NVM_WR_O(), .NVM_WDATA_O(),
		.RX_CHAR_I(rx_char), .REPLY_PENDING_I(pending),
		.TX_START_O(), .READY_O());

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	// Let registered outputs settle a fixed number of edges
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_startup;
		master.rd(ADR_MODE, v);
		chk("mode after reset", 16'h0000, v);
		meter_sp = 4'h9;
		cyc(2);
		chk("auto setpoints", {12'h000, 4'h9}, {12'h000, sp_out});
		master.rd(ADR_SPST, v);
		chk("state read", 16'h0009, v);
		master.rd(16'h9C62, v);
		chk("unused read", UNUSED_VAL, v);
	endtask

	// Analog written in auto is kept but not shown until manual
	task automatic t_analog;
		meter_ao = 12'h456;
		master.wr(ADR_AO_E, 16'h1FFF);
		cyc(2);
		chk("auto analog", 16'h0456, {4'h0, ao_out});
		master.rd(ADR_AO_E, v);
		chk("saturated level", AO_MAX_W, v);
		master.wr(ADR_MODE, 16'h0001);
		cyc(2);
		chk("manual flag", 16'h0001, {15'h0000, ao_man});
		chk("stored level", 16'h0FFF, {4'h0, ao_out});
		master.wr(ADR_AO_E, 16'h0123);
		cyc(2);
		chk("immediate level", 16'h0123, {4'h0, ao_out});
		master.wr(ADR_MODE, 16'h0000);
		cyc(2);
		chk("analog back auto", 16'h0456, {4'h0, ao_out});
	endtask

	// Mode bit 1 is setpoint four; the rest stay with the meter until all five go manual
	task automatic t_setpoint;
		meter_sp = 4'hA;
		cyc(1);
		master.wr(ADR_MODE, 16'h0002);
		meter_sp = 4'h5;
		cyc(2);
		chk("held on entry", 16'h000D, {12'h000, sp_out});
		master.wr(ADR_SPST, 16'h0000);
		cyc(2);
		chk("manual bit clear", 16'h0005, {12'h000, sp_out});
		master.wr(ADR_SPST, 16'h000F);
		meter_sp = 4'h0;
		cyc(2);
		chk("auto bits ignore", 16'h0008, {12'h000, sp_out});
		master.wr(ADR_MODE, 16'h001F);
		master.wr(ADR_SPST, 16'h0005);
		cyc(2);
		chk("outputs one three", 16'h0005, {12'h000, sp_out});
		master.rd(ADR_SPST, v);
		chk("state readback", 16'h0005, v);
		master.wr(ADR_MODE, 16'h0000);
	endtask

	// Delay reconciled to the larger value; reply gated by the timer
	task automatic t_delay;
		master.rd(ADR_DELAY_E, v);
		chk("power-up delay", 16'h0005, v);
		master.wr(ADR_DELAY_E, 16'h0001);
		chk("no store", 16'h0000, {15'h0000, nvm_wr});
		master.rd(ADR_DELAY_E, v);
		chk("low delay kept", 16'h0005, v);
		master.wr(ADR_DELAY_E, 16'h0003);
		chk("store pulse", 16'h0001, {15'h0000, nvm_wr});
		chk("store data", 16'h0003, nvm_wdata);
		rx_char = 1'b1;
		pending = 1'b1;
		cyc(1);
		rx_char = 1'b0;
		n = 0;
		while (tx_start !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		comparisons++;
		if (n < 3 * MSC - 1 || n > 3 * MSC + 3) begin
			fails++;
			$display("FAIL reply gap expected %0d seen %0d", 3 * MSC, n);
		end
		pending = 1'b0;
		cyc(2);
		chk("reply released", 16'h0000, {15'h0000, tx_start});
	endtask

	// Basic map: one manual bit for all; auto writes only clear
	task automatic t_basic;
		meter_sp = 4'h6;
		master.wr(ADR_CSR, 16'h0005);
		chk("auto clear pulse", 16'h000A, {12'h000, sp_clr_b});
		chk("ext never clears", 16'h0000, {12'h000, sp_clr});
		cyc(2);
		chk("auto not set", 16'h0006, {12'h000, sp_out_b});
		master.wr(ADR_CSR, 16'h0019);
		cyc(2);
		chk("basic manual", 16'h0009, {12'h000, sp_out_b});
		master.rd(ADR_CSR, v);
		chk("ext csr unused", UNUSED_VAL, v);
		chk("basic csr read", 16'h0019, rdata_b);
		master.wr(ADR_CSR, 16'h0000);
		chk("manual off clears", 16'h000F, {12'h000, sp_clr_b});
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		meter_sp = 4'h0;
		meter_ao = 12'h000;
		rx_char = 1'b0;
		pending = 1'b0;
		baud = 3'h7;
		d8 = 1'b1;
		par = 1'b0;
		nvm_valid = 1'b0;
		nvm_delay = 16'h0005;
		fails = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// Store not yet valid, so reconciliation must wait
		cyc(8);
		chk("waits for store", 16'h0000, {15'h0000, ready});
		nvm_valid = 1'b1;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk("ready", 16'h0001, {15'h0000, ready});
		t_startup();
		t_analog();
		t_setpoint();
		t_delay();
		t_basic();
		tally_and_finish();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(4 * 5000);
		fails++;
		tally_and_finish();
	end
endmodule
